//--- design/dscp_top.sv
// Dual serial control port: three-wire shift port and two-wire slave.
// Assumes a register bank on i_clk that decodes o_reg and returns the
// addressed byte on i_reg_rdata combinationally from o_reg.index.
`timescale 1ns/1ps
module dscp_top #(
  // Fixed upper address bits; this value is arbitrary.
  parameter logic [dscp_pkg::ADDR_FIX_W-1:0] SLAVE_FIXED = 5'h0a
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ctrl_shift_clock,
  input wire logic i_ctrl_serial_in,
  input wire logic i_ctrl_port_select_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_slave_addr_pin_bit0,
  input wire logic i_slave_addr_pin_bit1,
  input wire logic [1:0] i_if_select,
  input wire logic [dscp_pkg::DATA_W-1:0] i_reg_rdata,
  output logic o_sda_out,
  output logic o_sda_oe,
  output dscp_pkg::dscp_regreq_s o_reg,
  output dscp_pkg::dscp_mode_e o_ctrl_mode
);
  import dscp_pkg::*;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    I_IDLE = 4'h0,
    I_ADDR = 4'h1,
    I_AACK = 4'h2,
    I_INDEX = 4'h3,
    I_IACK = 4'h4,
    I_WDATA = 4'h5,
    I_WACK = 4'h6,
    I_RDATA = 4'h7,
    I_RACK = 4'h8,
    I_WAIT = 4'h9
  } dscp_i2c_e;

  // Per-frame shift state; cleared whenever select is high.
  typedef struct packed {
    logic [4:0] cnt;
    logic [15:0] shf;
    logic first_done;
    logic drop;
  } dscp_lframe_s;

  // Completed words and their pointer; only the main reset clears them.
  typedef struct packed {
    dscp_word_s [SLOT_N-1:0] slot;
    logic [PTR_W-1:0] wptr;
    logic [PTR_W-1:0] wgray;
    logic [IDX_W-1:0] last_addr;
  } dscp_lout_s;

  // Everything on i_clk.
  typedef struct packed {
    logic [2:0] settle;
    logic mode_taken;
    dscp_mode_e mode;
    logic [PTR_W-1:0] rptr;
    logic pend_valid;
    dscp_word_s pend;
    logic [1:0] close;
    logic sel_prev;
    logic scl_prev;
    logic sda_prev;
    dscp_i2c_e i2c;
    logic [3:0] bcnt;
    logic [7:0] shf;
    logic rw;
    logic [IDX_W-1:0] idx;
    logic sda_oe;
    logic sda_out;
    dscp_regreq_s reg_req;
  } dscp_core_s;

  // ----------------------------------------------------------------------
  // Shift clock domain
  // ----------------------------------------------------------------------
  dscp_lframe_s lf;
  dscp_lframe_s next_lf;
  dscp_lout_s lo;
  dscp_lout_s next_lo;
  logic lk_rst_n; // Frame reset: main reset or port deselected.
  logic [15:0] lk_shift;
  logic [4:0] lk_cnt;
  dscp_word_s lk_word;

  assign lk_rst_n = i_rstn & ~i_ctrl_port_select_n;

  // Assemble words; the first carries flag and index, later ones data.
  always_comb begin
    next_lf = lf;
    next_lo = lo;
    lk_shift = {lf.shf[14:0], i_ctrl_serial_in};
    lk_cnt = lf.cnt + 5'h01;
    lk_word.addr = lk_shift[DATA_W +: IDX_W];
    lk_word.data = lk_shift[DATA_W-1:0];
    next_lf.shf = lk_shift;
    next_lf.cnt = lk_cnt;
    if (lk_cnt == (lf.first_done ? SPI_NEXT_BITS : SPI_FIRST_BITS)) begin
      next_lf.cnt = '0;
      next_lf.first_done = 1'b1;
      if (!lf.first_done) begin
        // A frame not opening with the write flag is ignored whole.
        next_lf.drop = (lk_shift[SPI_FLAG_POS] != SPI_WRITE_VAL);
      end else begin
        lk_word.addr = dscp_next_index(lo.last_addr);
      end
      if (!next_lf.drop) begin
        next_lo.slot[lo.wptr] = lk_word;
        next_lo.last_addr = lk_word.addr;
        next_lo.wptr = lo.wptr + 2'h1;
        next_lo.wgray = dscp_bin2gray(next_lo.wptr);
      end
    end
  end

  // The shift clock is free of any audio clock relation. It stops
  // between frames, so the frame state is cleared by select itself.
  always_ff @(posedge i_ctrl_shift_clock or negedge lk_rst_n) begin
    if (!lk_rst_n) begin
      lf <= '0;
    end else begin
      lf <= next_lf;
    end
  end

  // Slots keep their contents across frames until the core reads them.
  always_ff @(posedge i_ctrl_shift_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      lo <= '0;
    end else begin
      lo <= next_lo;
    end
  end

  // ----------------------------------------------------------------------
  // Crossings into i_clk
  // ----------------------------------------------------------------------
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pins_s;
  logic [PTR_W-1:0] wgray_s;

  assign pins = {i_if_select, i_slave_addr_pin_bit1, i_slave_addr_pin_bit0,
                 i_ctrl_port_select_n, i_sda, i_scl};

  // Pins pass three flops with agreement before use.
  dscp_sync #(.W(PIN_W), .RST_VAL(PIN_IDLE)) u_pin_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(pins),
    .o_sync(pins_s)
  );

  // The gray pointer changes one bit per word, so agreement is safe.
  dscp_sync #(.W(PTR_W), .RST_VAL('0)) u_ptr_sync (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_async(lo.wgray),
    .o_sync(wgray_s)
  );

  // ----------------------------------------------------------------------
  // Core on i_clk
  // ----------------------------------------------------------------------
  dscp_core_s c;
  dscp_core_s n;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic avail;
  logic [1:0] strap;

  assign scl = pins_s[PIN_SCL];
  assign sda = pins_s[PIN_SDA];
  assign strap = pins_s[PIN_MODE +: 2];

  // One combinational pass computes every next value of the core.
  always_comb begin
    n = c;
    n.reg_req.wr = 1'b0;
    n.sel_prev = pins_s[PIN_SEL];
    n.scl_prev = scl;
    n.sda_prev = sda;
    scl_rise = scl & ~c.scl_prev;
    scl_fall = ~scl & c.scl_prev;
    // Edges on the data line while the clock is high frame a transfer.
    bus_start = c.scl_prev & scl & c.sda_prev & ~sda;
    bus_stop = c.scl_prev & scl & ~c.sda_prev & sda;
    avail = (c.rptr != dscp_gray2bin(wgray_s));

    // Strap taken once, a few cycles after release, then frozen.
    if (!c.mode_taken) begin
      n.settle = c.settle + 3'h1;
      // The synchroniser shows the strap only after the fourth edge, so
      // it is read one edge later; earlier it would still be the idle code.
      if (c.settle == MODE_SETTLE) begin
        n.mode_taken = 1'b1;
        case (strap)
          2'b00: n.mode = MODE_I2C;
          2'b10: n.mode = MODE_SPI;
          default: n.mode = MODE_PARALLEL;
        endcase
      end
    end

    // Three-wire commits: a word is held until the next word or close.
    if (c.mode == MODE_SPI) begin
      if (pins_s[PIN_SEL] && !c.sel_prev) begin
        n.close = SPI_CLOSE_WAIT;
      end
      if (avail) begin
        if (c.pend_valid) begin
          n.reg_req.wr = 1'b1;
          n.idx = c.pend.addr;
          n.reg_req.index = c.pend.addr;
          n.reg_req.wdata = c.pend.data;
        end
        n.pend = lo.slot[c.rptr];
        n.pend_valid = 1'b1;
        n.rptr = c.rptr + 2'h1;
      end else if (c.close == 2'h1) begin
        // Waiting lets a word that finished just before select rose
        // arrive first, so it is not left pending into the next frame.
        n.close = 2'h0;
        n.pend_valid = 1'b0;
        if (c.pend_valid) begin
          n.reg_req.wr = 1'b1;
          n.idx = c.pend.addr;
          n.reg_req.index = c.pend.addr;
          n.reg_req.wdata = c.pend.data;
        end
      end else if (c.close != 2'h0) begin
        n.close = c.close - 2'h1;
      end
    end

    // Two-wire slave; it watches the clock and never drives it.
    if (c.mode != MODE_I2C) begin
      n.i2c = I_IDLE;
    end else if (bus_start) begin
      // A repeated start keeps the index loaded by the write phase.
      n.i2c = I_ADDR;
      n.bcnt = '0;
      n.sda_oe = 1'b0;
    end else if (bus_stop) begin
      n.i2c = I_IDLE;
      n.sda_oe = 1'b0;
    end else begin
      case (c.i2c)
        I_ADDR, I_INDEX, I_WDATA: begin
          if (scl_rise) begin
            n.shf = {c.shf[6:0], sda};
            n.bcnt = c.bcnt + 4'h1;
          end else if (scl_fall && c.bcnt == I2C_BYTE_BITS) begin
            n.bcnt = '0;
            n.i2c = I_WAIT;
            if (c.i2c == I_ADDR) begin
              n.rw = c.shf[0];
              if (c.shf[7:1] == {SLAVE_FIXED, i_slave_addr_pin_bit1_s(),
                                 pins_s[PIN_A0]}
                  && !(c.shf[0] && !dscp_is_defined({1'b0, c.idx}))) begin
                n.sda_oe = (ACK_LEVEL == 1'b0);
                n.i2c = I_AACK;
              end
            end else if (c.i2c == I_INDEX) begin
              n.idx = c.shf[IDX_W-1:0];
              if (dscp_is_defined(c.shf)) begin
                n.sda_oe = (ACK_LEVEL == 1'b0);
                n.i2c = I_IACK;
              end
            end else if (dscp_is_defined({1'b0, c.idx})) begin
              n.reg_req.wr = 1'b1;
              n.reg_req.index = c.idx;
              n.reg_req.wdata = c.shf;
              n.idx = dscp_next_index(c.idx);
              n.sda_oe = (ACK_LEVEL == 1'b0);
              n.i2c = I_WACK;
            end
          end
        end
        I_AACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            if (c.rw) begin
              n.shf = i_reg_rdata;
              n.sda_oe = ~i_reg_rdata[7];
              n.i2c = I_RDATA;
            end else begin
              n.i2c = I_INDEX;
            end
          end
        end
        I_IACK, I_WACK: begin
          if (scl_fall) begin
            n.sda_oe = 1'b0;
            n.i2c = I_WDATA;
          end
        end
        I_RDATA: begin
          if (scl_rise) begin
            n.bcnt = c.bcnt + 4'h1;
          end else if (scl_fall) begin
            if (c.bcnt == I2C_BYTE_BITS) begin
              n.bcnt = '0;
              n.sda_oe = 1'b0;
              n.i2c = I_RACK;
            end else begin
              n.shf = {c.shf[6:0], 1'b0};
              n.sda_oe = ~c.shf[6];
            end
          end
        end
        I_RACK: begin
          if (scl_rise) begin
            if (sda == ACK_LEVEL) begin
              n.idx = dscp_next_index(c.idx);
            end else begin
              n.i2c = I_WAIT;
            end
          end else if (scl_fall) begin
            n.shf = i_reg_rdata;
            n.sda_oe = ~i_reg_rdata[7];
            n.i2c = I_RDATA;
          end
        end
        I_WAIT: begin
          n.sda_oe = 1'b0;
        end
        default: begin
          n.i2c = I_IDLE;
        end
      endcase
    end
    if (!n.reg_req.wr) begin
      n.reg_req.index = n.idx;
    end
  end

  // Address pin 1 as seen after the synchroniser.
  function automatic logic i_slave_addr_pin_bit1_s();
    i_slave_addr_pin_bit1_s = pins_s[PIN_A1];
  endfunction : i_slave_addr_pin_bit1_s

  // Core register; idle index points at the first defined register.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      c <= '{settle: 3'h0, mode_taken: 1'b0, mode: MODE_PARALLEL,
             rptr: '0, pend_valid: 1'b0, pend: '0, close: 2'h0,
             sel_prev: 1'b1, scl_prev: 1'b1, sda_prev: 1'b1,
             i2c: I_IDLE, bcnt: 4'h0, shf: 8'h00, rw: 1'b0,
             idx: REG_FIRST, sda_oe: 1'b0, sda_out: 1'b0,
             reg_req: '{wr: 1'b0, index: REG_FIRST, wdata: 8'h00}};
    end else begin
      c <= n;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from the core register
  // ----------------------------------------------------------------------
  // Open drain: the level driven is always low, the enable carries data.
  assign o_sda_out = c.sda_out;
  assign o_sda_oe = c.sda_oe;
  assign o_reg = c.reg_req;
  assign o_ctrl_mode = c.mode;

endmodule : dscp_top

//--- pkg/dscp_pkg.sv
// Shared constants, carrier types and helpers for the dual serial control
// port. Assumes a bank of 8-bit registers reached through a 7-bit index.
package dscp_pkg;

  // ----------------------------------------------------------------------
  // Widths and register window
  // ----------------------------------------------------------------------
  localparam int IDX_W = 7;
  localparam int DATA_W = 8;
  // Defined register window; auto increment wraps from last to first.
  localparam logic [IDX_W-1:0] REG_FIRST = 7'h40;
  localparam logic [IDX_W-1:0] REG_LAST = 7'h4f;

  // ----------------------------------------------------------------------
  // Three-wire framing
  // ----------------------------------------------------------------------
  localparam logic [4:0] SPI_FIRST_BITS = 5'h10;
  localparam logic [4:0] SPI_NEXT_BITS = 5'h08;
  localparam int SPI_FLAG_POS = 15;
  localparam logic SPI_WRITE_VAL = 1'b0;
  // Cycles a closing select edge waits for a late word to cross over.
  localparam logic [1:0] SPI_CLOSE_WAIT = 2'h3;
  // Word slots shared with the shift clock domain.
  localparam int PTR_W = 2;
  localparam int SLOT_N = 4;

  // ----------------------------------------------------------------------
  // Two-wire framing
  // ----------------------------------------------------------------------
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam logic ACK_LEVEL = 1'b0;
  localparam int ADDR_FIX_W = 5;

  // ----------------------------------------------------------------------
  // Pin bundle positions and start-up timing
  // ----------------------------------------------------------------------
  localparam int PIN_W = 7;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_SEL = 2;
  localparam int PIN_A0 = 3;
  localparam int PIN_A1 = 4;
  localparam int PIN_MODE = 5;
  // Idle levels of the pins: lines high, mode field reads as parallel.
  localparam logic [PIN_W-1:0] PIN_IDLE = 7'h3f;
  // Cycles after reset release before the mode strap is taken.
  localparam logic [2:0] MODE_SETTLE = 3'h4;

  // Control interface chosen by the strap at reset release.
  typedef enum logic [1:0] {
    MODE_I2C = 2'b00,
    MODE_PARALLEL = 2'b01,
    MODE_SPI = 2'b10
  } dscp_mode_e;

  // One register index with its data byte.
  typedef struct packed {
    logic [IDX_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dscp_word_s;

  // Write request towards the register bank.
  typedef struct packed {
    logic wr;
    logic [IDX_W-1:0] index;
    logic [DATA_W-1:0] wdata;
  } dscp_regreq_s;

  // Next index with wrap at the top of the window.
  function automatic logic [IDX_W-1:0] dscp_next_index(
      input logic [IDX_W-1:0] idx);
    dscp_next_index = (idx == REG_LAST) ? REG_FIRST : idx + 7'h01;
  endfunction : dscp_next_index

  // True when an 8-bit index byte names a defined register.
  function automatic logic dscp_is_defined(input logic [7:0] idx);
    dscp_is_defined = (idx >= {1'b0, REG_FIRST}) &&
                      (idx <= {1'b0, REG_LAST});
  endfunction : dscp_is_defined

  // Two-bit gray coding for the slot pointer crossing.
  function automatic logic [PTR_W-1:0] dscp_bin2gray(
      input logic [PTR_W-1:0] b);
    dscp_bin2gray = b ^ (b >> 1);
  endfunction : dscp_bin2gray

  function automatic logic [PTR_W-1:0] dscp_gray2bin(
      input logic [PTR_W-1:0] g);
    dscp_gray2bin = {g[1], g[1] ^ g[0]};
  endfunction : dscp_gray2bin

endpackage : dscp_pkg

//--- design/dscp_sync.sv
// Three-flop input synchroniser with agreement filter.
// Assumes inputs are asynchronous to i_clk; output moves only when the
// second and third stages agree.
`timescale 1ns/1ps
module dscp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  import dscp_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  // The first stage feeds only the second; nothing else looks at it.
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } dscp_sync_s;

  dscp_sync_s st;
  dscp_sync_s next_st;
  logic [W-1:0] differ;

  // Shift the chain; the filtered value holds while stages disagree.
  always_comb begin
    differ = st.s2 ^ st.s3;
    next_st.s1 = i_async;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q = (~differ & st.s3) | (differ & st.q);
  end

  // Reset loads idle levels so no false edge appears on release.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st <= {4{RST_VAL}};
    end else begin
      st <= next_st;
    end
  end

  assign o_sync = st.q;

endmodule : dscp_sync

//--- verification/dscp_checker.sv
// Concurrent checks on the pins of the dual serial control port.
// Assumes every check runs on the core clock; pin inputs are asynchronous.
`timescale 1ns/1ps
module dscp_checker (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ctrl_shift_clock,
  input wire logic i_ctrl_serial_in,
  input wire logic i_ctrl_port_select_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_slave_addr_pin_bit0,
  input wire logic i_slave_addr_pin_bit1,
  input wire logic [1:0] i_if_select,
  input wire logic [dscp_pkg::DATA_W-1:0] i_reg_rdata,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire dscp_pkg::dscp_regreq_s o_reg,
  input wire dscp_pkg::dscp_mode_e o_ctrl_mode
);
  import dscp_pkg::*;
  logic [2:0] up_cnt; // Cycles since reset release, saturating.
  logic [IDX_W-1:0] wr_idx; // Index of the last write.
  // Helper state; the strap settles well before the count saturates.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      up_cnt <= 3'h0;
      wr_idx <= 7'h00;
    end else begin
      if (up_cnt != 3'h7) begin
        up_cnt <= up_cnt + 3'h1;
      end
      if (o_reg.wr) begin
        wr_idx <= o_reg.index;
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_sda_only_low: assert property (o_sda_out == 1'b0)
    else $error("data line driven high");
  a_mode_held: assert property (up_cnt == 3'h7 |-> $stable(o_ctrl_mode))
    else $error("mode changed after start-up");
  a_wr_one_cycle: assert property (o_reg.wr |=> !o_reg.wr)
    else $error("write strobe longer than one cycle");
  a_wr_needs_mode: assert property (o_reg.wr |-> o_ctrl_mode != MODE_PARALLEL)
    else $error("write while no serial port chosen");
  a_quiet_not_i2c: assert property (o_ctrl_mode != MODE_I2C |-> !o_sda_oe)
    else $error("data line driven outside two-wire mode");
  a_i2c_window: assert property (o_reg.wr && o_ctrl_mode == MODE_I2C
    |-> o_reg.index inside {[REG_FIRST:REG_LAST]})
    else $error("two-wire write outside the register window");
  a_index_step: assert property (o_reg.wr && o_ctrl_mode == MODE_I2C
    |=> ##[0:3] o_reg.index == ((wr_idx == 7'h4f) ? 7'h40 : wr_idx + 7'h01))
    else $error("index did not advance after a write");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line moved while clock high");
endmodule : dscp_checker

bind dscp_top dscp_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
  .i_ctrl_shift_clock(i_ctrl_shift_clock),
  .i_ctrl_serial_in(i_ctrl_serial_in),
  .i_ctrl_port_select_n(i_ctrl_port_select_n), .i_scl(i_scl),
  .i_sda(i_sda), .i_slave_addr_pin_bit0(i_slave_addr_pin_bit0),
  .i_slave_addr_pin_bit1(i_slave_addr_pin_bit1), .i_if_select(i_if_select),
  .i_reg_rdata(i_reg_rdata), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_reg(o_reg), .o_ctrl_mode(o_ctrl_mode));

//--- verification/dscp_host.sv
// Host controller model: two-wire master and three-wire shift master.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
module dscp_host (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low,
  output logic o_sck,
  output logic o_mosi,
  output logic o_sel_n
);
  // Idle: bus released, select high, shift clock stopped.
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_sck = 1'b0;
    o_mosi = 1'b0;
    o_sel_n = 1'b1;
  end
  // Quarter bit: five core cycles, so each clock phase lasts ten.
  task automatic q;
    repeat (5) @(posedge i_clk);
    #1;
  endtask : q
  // Start, also used as repeated start from a low clock.
  task automatic start;
    o_sda_low = 1'b0;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b0;
    q();
  endtask : start
  task automatic stop;
    o_sda_low = 1'b1;
    q();
    o_scl = 1'b1;
    q();
    o_sda_low = 1'b0;
    q();
  endtask : stop
  // One bit: drive b (1 releases), sample the wire in mid high phase.
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    q();
    o_scl = 1'b1;
    q();
    r = i_sda;
    q();
    o_scl = 1'b0;
    q();
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic ackb,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ackb, ack);
  endtask : xfer
  // Shift frame of n bits from the top of w; clock runs only inside it.
  task automatic spi(input logic [31:0] w, input int n);
    @(posedge i_clk);
    #7;
    o_sel_n = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      o_mosi = w[31-i];
      #6 o_sck = 1'b1;
      #6 o_sck = 1'b0;
    end
    #20 o_sel_n = 1'b1;
    o_mosi = ~o_mosi; // Released line no longer shows the last bit.
    #600;
  endtask : spi
endmodule : dscp_host

//--- verification/dscp_top_tb.sv
// Self-checking bench for the dual serial control port.
// Assumes a 16-byte register bank model answering reads from the index.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin \
  n_errors++; $display("CHECK FAILED %s expected %0h seen %0h", nm, \
  (exp), (got)); end end
module dscp_top_tb;
  import dscp_pkg::*;
  localparam logic [4:0] SF = 5'h0c; // Arbitrary fixed address bits.
  logic clk, rstn, a0, a1, scl, sda_low, sck, mosi, sel_n, sda_w;
  logic sda_out, sda_oe;
  logic [1:0] strap;
  logic [7:0] rdata;
  logic [7:0] mem [16];
  dscp_regreq_s req;
  dscp_mode_e mode;
  dscp_word_s wlog[$]; // Writes seen at the bank, oldest first.
  int n_errors = 0;
  int n_compared = 0;
  assign sda_w = !(sda_low || sda_oe); // Open drain with pull-up.
  assign rdata = mem[req.index[3:0]];
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Bank model: store and log every write strobe.
  always @(posedge clk) begin
    if (req.wr === 1'b1) begin
      mem[req.index[3:0]] <= req.wdata;
      wlog.push_back({req.index, req.wdata});
    end
  end
  dscp_top #(.SLAVE_FIXED(SF)) DUT (.i_clk(clk), .i_rstn(rstn),
    .i_ctrl_shift_clock(sck), .i_ctrl_serial_in(mosi),
    .i_ctrl_port_select_n(sel_n), .i_scl(scl), .i_sda(sda_w),
    .i_slave_addr_pin_bit0(a0), .i_slave_addr_pin_bit1(a1),
    .i_if_select(strap), .i_reg_rdata(rdata), .o_sda_out(sda_out),
    .o_sda_oe(sda_oe), .o_reg(req), .o_ctrl_mode(mode));
  dscp_host host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl),
    .o_sda_low(sda_low), .o_sck(sck), .o_mosi(mosi), .o_sel_n(sel_n));
  task automatic do_reset(input logic [1:0] s, input dscp_mode_e m);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    strap = s;
    repeat (5) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    strap = ~s; // A late strap change must not matter.
    repeat (4) @(posedge clk);
    #1;
    `CHK("mode", m, mode)
    strap = s;
    wlog.delete();
  endtask : do_reset
  task automatic expect_wr(input logic [6:0] a, input logic [7:0] d);
    dscp_word_s w;
    w = '0;
    if (wlog.size() != 0) w = wlog.pop_front();
    `CHK("write index", a, w.addr)
    `CHK("write data", d, w.data)
  endtask : expect_wr
  task automatic t_spi;
    do_reset(2'b10, MODE_SPI);
    host.spi(32'h42a50000, 16);
    host.spi(32'hc3110000, 16); // Read flag: frame is dropped.
    host.spi(32'h44770000, 12); // Short frame is dropped.
    host.spi(32'h4f112233, 32);
    expect_wr(7'h42, 8'ha5);
    expect_wr(7'h4f, 8'h11);
    expect_wr(7'h40, 8'h22);
    expect_wr(7'h41, 8'h33);
    `CHK("spi extra writes", 0, wlog.size())
    $display("shift port test done");
  endtask : t_spi
  // Parallel strap: neither serial port may answer or write.
  task automatic t_par;
    logic [7:0] rx;
    logic ack;
    do_reset(2'b01, MODE_PARALLEL);
    host.spi(32'h42a50000, 16);
    host.start();
    host.xfer({SF, a1, a0, 1'b0}, 1'b1, rx, ack);
    host.stop();
    `CHK("parallel ack", 1'b1, ack)
    `CHK("parallel writes", 0, wlog.size())
    $display("parallel strap test done");
  endtask : t_par
  task automatic t_i2c_wr;
    logic [7:0] rx;
    logic ack;
    logic [7:0] tx [4] = '{8'h4e, 8'h61, 8'h62, 8'h63};
    do_reset(2'b00, MODE_I2C);
    host.spi(32'h42a50000, 16); // Shift port is inert in this mode.
    host.start();
    host.xfer({SF, a1, a0, 1'b0}, 1'b1, rx, ack);
    `CHK("addr ack", ACK_LEVEL, ack)
    for (int i = 0; i < 4; i++) begin
      host.xfer(tx[i], 1'b1, rx, ack);
      `CHK("byte ack", ACK_LEVEL, ack)
    end
    host.stop();
    expect_wr(7'h4e, 8'h61);
    expect_wr(7'h4f, 8'h62);
    expect_wr(7'h40, 8'h63);
    `CHK("i2c extra writes", 0, wlog.size())
    $display("two-wire write test done");
  endtask : t_i2c_wr
  task automatic t_i2c_rd;
    logic [7:0] rx;
    logic ack;
    host.start();
    host.xfer({SF, a1, a0, 1'b0}, 1'b1, rx, ack);
    host.xfer(8'h4e, 1'b1, rx, ack);
    host.start();
    host.xfer({SF, a1, a0, 1'b1}, 1'b1, rx, ack);
    `CHK("read addr ack", ACK_LEVEL, ack)
    host.xfer(8'hff, 1'b0, rx, ack);
    `CHK("read byte 1", 8'h61, rx)
    host.xfer(8'hff, 1'b1, rx, ack);
    `CHK("read byte 2", 8'h62, rx)
    host.stop();
    `CHK("released", 1'b0, sda_oe)
    `CHK("sda level", 1'b0, sda_out)
    host.start();
    host.xfer({SF, a1, ~a0, 1'b0}, 1'b1, rx, ack);
    `CHK("other addr nack", 1'b1, ack)
    host.stop();
    host.start();
    host.xfer({SF, a1, a0, 1'b0}, 1'b1, rx, ack);
    host.xfer(8'h50, 1'b1, rx, ack);
    `CHK("bad index nack", 1'b1, ack)
    host.xfer(8'h99, 1'b1, rx, ack);
    host.stop();
    `CHK("no write", 0, wlog.size())
    $display("two-wire read test done");
  endtask : t_i2c_rd
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  initial begin
    rstn = 1'b0;
    strap = 2'b10;
    a0 = 1'b1;
    a1 = 1'b0;
    for (int i = 0; i < 16; i++) mem[i] = 8'h00;
    t_spi();
    t_par();
    t_i2c_wr();
    t_i2c_rd();
    results();
  end
  // Watchdog: the tests need well under a quarter of this span.
  initial begin
    #1000000;
    n_errors++;
    results();
  end
endmodule : dscp_top_tb
